// ### hw/pcr_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the PLL
  configuration word decoder. Assumes 32-bit words with select in bits 2:0.
*/
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH
`define PCR_SEL_INT_FRACTION 3'h0
`define PCR_SEL_MODULUS_PHASE 3'h1
`define PCR_SEL_REF_LOOP 3'h2
`define PCR_SEL_OUT_CTRL 3'h4
`define PCR_SEL_LOCK_PIN 3'h5
`define PCR_INT_LSB 15
`define PCR_FRACTION_LSB 3
`define PCR_PRESCALER_BIT 27
`define PCR_PHASE_LSB 15
`define PCR_MODULUS_LSB 3
`define PCR_NOISE_LSB 29
`define PCR_MUX_LSB 26
`define PCR_DOUBLER_BIT 25
`define PCR_HALVER_BIT 24
`define PCR_RCNT_LSB 14
`define PCR_DBUF_BIT 13
`define PCR_CP_LSB 9
`define PCR_LCOUNT_BIT 8
`define PCR_LWIN_BIT 7
`define PCR_OUTDIV_LSB 20
`define PCR_BACKLASH_LSB 30
`define PCR_CCE_BIT 29
`define PCR_LDPIN_LSB 22
`define PCR_NOISE_LOW_SPUR 2'h3
`define PCR_RST_INT 16'h0000
`define PCR_RST_MODULUS 12'h001
`define PCR_RST_PHASE 12'h001
`define PCR_RST_RCNT 10'h001
`define PCR_LOCK_CNT_LONG 40
`define PCR_LOCK_CNT_SHORT 5
`define PCR_CLK_PERIOD_NS 5
`define PCR_LOCK_WIN_WIDE_NS 10
`define PCR_LOCK_WIN_NARROW_NS 6
`endif

// ### hw/pcr_pkg.sv
/*
  Types shared by the PLL configuration decoder and its lock detector.
  Assumes nothing beyond the constants header.
*/
package pcr_pkg;
  typedef logic [2:0] pcr_sel_t;
  typedef enum logic [1:0] {LK_IDLE, LK_WAIT} pcr_lock_e;
endpackage

// ### hw/pcr_lock_if.sv
/*
  Carrier between the decoder core and the digital lock detector.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface pcr_lock_if;
  logic refTick;
  logic fbEdge;
  logic lockCountSelect;
  logic lockWindowSelect;
  logic lockDet;
  modport core (output refTick, output fbEdge, output lockCountSelect,
    output lockWindowSelect, input lockDet);
  modport det (input refTick, input fbEdge, input lockCountSelect,
    input lockWindowSelect, output lockDet);
endinterface
`default_nettype wire

// ### hw/pcr_lock_detect.sv
/*
  Digital lock detector: measures the gap between the reference and feedback
  edges of each detector cycle. Assumes one-cycle edge pulses on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcr_regs.svh"
module pcr_lock_detect (
  input wire logic ref_clk,
  input wire logic rstn,
  pcr_lock_if.det lk
);
  import pcr_pkg::*;
  localparam int WIDE_CYC = (`PCR_LOCK_WIN_WIDE_NS / `PCR_CLK_PERIOD_NS < 1) ? 1 :
    `PCR_LOCK_WIN_WIDE_NS / `PCR_CLK_PERIOD_NS;
  localparam int NARROW_CYC = (`PCR_LOCK_WIN_NARROW_NS / `PCR_CLK_PERIOD_NS < 1) ? 1 :
    `PCR_LOCK_WIN_NARROW_NS / `PCR_CLK_PERIOD_NS;
  pcr_lock_e state_ff;
  logic [7:0] gap_ff;
  logic [5:0] good_ff;
  logic lock_ff;
  logic cycDone;
  logic [7:0] errCyc;
  logic [7:0] winCyc;
  logic [5:0] need;
  logic inWin;

  // both edges together in LK_IDLE is a zero-error cycle
  assign cycDone = (lk.refTick && lk.fbEdge) ||
    (state_ff == LK_WAIT && (lk.refTick || lk.fbEdge));
  assign errCyc = (lk.refTick && lk.fbEdge && state_ff == LK_IDLE) ? 8'h00 : gap_ff;
  assign winCyc = lk.lockWindowSelect ? 8'(NARROW_CYC) : 8'(WIDE_CYC);
  assign need = lk.lockCountSelect ? 6'(`PCR_LOCK_CNT_SHORT) : 6'(`PCR_LOCK_CNT_LONG);
  assign inWin = errCyc <= winCyc;
  assign lk.lockDet = lock_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= LK_IDLE;
      gap_ff <= 8'h00;
    end else begin
      case (state_ff)
        LK_IDLE: begin
          gap_ff <= 8'h01;
          if ((lk.refTick ^ lk.fbEdge)) state_ff <= LK_WAIT;
        end
        LK_WAIT: begin
          // saturate so a lost edge reads as a huge error
          if (gap_ff != 8'hFF) gap_ff <= gap_ff + 8'h01;
          if (lk.refTick || lk.fbEdge) state_ff <= LK_IDLE;
        end
        default: state_ff <= LK_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      good_ff <= 6'h00;
      lock_ff <= 1'b0;
    end else if (cycDone) begin
      if (!inWin) begin
        good_ff <= 6'h00;
        lock_ff <= 1'b0;
      end else if (good_ff + 6'h01 >= need) begin
        good_ff <= need;
        lock_ff <= 1'b1;
      end else begin
        good_ff <= good_ff + 6'h01;
      end
    end
  end

  sequence s_bad_cycle;
    cycDone && !inWin;
  endsequence
  a_lock_drop_bad: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_bad_cycle |=> !lock_ff && good_ff == 6'h00)
    else $error("lock held through an out-of-window cycle");
  a_lock_needs_count: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(lock_ff) |-> $past(good_ff) + 6'h01 >= $past(need))
    else $error("lock asserted before enough good cycles");
  a_window_width: assert property (@(posedge ref_clk) disable iff (!rstn)
    winCyc == (lk.lockWindowSelect ? 8'h01 : 8'h02))
    else $error("lock window not 6 ns or 10 ns");
endmodule // pcr_lock_detect
`default_nettype wire

// ### hw/pcr_top.sv
/*
  PLL configuration word decoder: shifts serial words in, decodes the select
  bits on the latch strobe, holds buffered fields, derives the detector
  reference tick and drives the lock detector. Assumes the serial pins and the
  reference input are synchronous to ref_clk and slower than it.
*/
// How it works
// - select 000 loads integer/fraction word
// - select 001 loads modulus/phase/prescaler word
// - select 010 loads reference/loop control word
// - integer value sits in bits 30:15
// - fraction numerator sits in bits 14:3
// - bit 27 picks prescaler 4/5 or 8/9
// - phase word bits 26:15, above modulus
// - fraction modulus sits in bits 14:3
// - bits 30:29 pick noise mode, dither
// - bits 28:26 steer the test mux
// - doubler: falling edge or both edges
// - halver toggle between R counter and detector
// - ten-bit reference divider, ratios 1..1023
// - bit 13 buffers output divider select
// - buffered fields apply on integer write
// - bits 11:9 give charge pump current
// - lock count 40 or 5 cycles
// - lock window 10 ns or 6 ns
// - lock after consecutive good cycles only
// - select 101 loads lock pin word
`timescale 1ns/100ps
`default_nettype none
`include "pcr_regs.svh"
module pcr_top #(
  parameter int WORD_W = 32
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic serClk,
  input wire logic serData,
  input wire logic latchEn,
  input wire logic refIn,
  input wire logic fbEdge,
  output logic [15:0] integerValue,
  output logic [11:0] fraction_numerator,
  output logic [11:0] fraction_modulus,
  output logic [11:0] phaseValue,
  output logic prescaler_select,
  output logic [1:0] noiseMode,
  output logic ditherEn,
  output logic [2:0] testMuxSel,
  output logic test_mux_output,
  output logic [2:0] cpCurrent,
  output logic [2:0] outDivSel,
  output logic [1:0] antibacklash_width,
  output logic charge_cancel_enable,
  output logic [1:0] lockPinMode,
  output logic detRefTick,
  output logic lockDetect,
  output pcr_pkg::pcr_sel_t lastSel
);
  import pcr_pkg::*;
  if (WORD_W != 32) begin : g_bad_width
    $error("pcr_top serves 32-bit words only");
  end

  logic [WORD_W-1:0] shift_ff;
  logic serClk_ff;
  logic latch_ff;
  logic refIn_ff;
  logic serRise;
  logic latchRise;
  logic [WORD_W-1:0] word;
  pcr_sel_t sel;
  logic wrIntFraction;
  logic wrModulusPhase;
  logic wrRefLoop;
  logic wrOutCtrl;

  assign serRise = serClk && !serClk_ff;
  assign latchRise = latchEn && !latch_ff;
  assign word = shift_ff;
  assign sel = word[2:0];
  assign wrIntFraction = latchRise && sel == `PCR_SEL_INT_FRACTION;
  assign wrModulusPhase = latchRise && sel == `PCR_SEL_MODULUS_PHASE;
  assign wrRefLoop = latchRise && sel == `PCR_SEL_REF_LOOP;
  assign wrOutCtrl = latchRise && sel == `PCR_SEL_OUT_CTRL;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      serClk_ff <= 1'b0;
      latch_ff <= 1'b0;
      refIn_ff <= 1'b0;
    end else begin
      serClk_ff <= serClk;
      latch_ff <= latchEn;
      refIn_ff <= refIn;
    end
  end

  // data shifted while the latch is high is still taken; the strobe edge decides
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) shift_ff <= '0;
    else if (serRise) shift_ff <= {shift_ff[WORD_W-2:0], serData};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) lastSel <= 3'h0;
    else if (latchRise) lastSel <= sel;
  end

  // integer/fraction word: also the apply strobe for every buffered field
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      integerValue <= `PCR_RST_INT;
      fraction_numerator <= 12'h000;
    end else if (wrIntFraction) begin
      integerValue <= word[`PCR_INT_LSB +: 16];
      fraction_numerator <= word[`PCR_FRACTION_LSB +: 12];
    end
  end

  logic [11:0] modulusShadow_ff;
  logic [11:0] phaseShadow_ff;
  logic prescShadow_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      modulusShadow_ff <= `PCR_RST_MODULUS;
      phaseShadow_ff <= `PCR_RST_PHASE;
      prescShadow_ff <= 1'b0;
    end else if (wrModulusPhase) begin
      modulusShadow_ff <= word[`PCR_MODULUS_LSB +: 12];
      phaseShadow_ff <= word[`PCR_PHASE_LSB +: 12];
      prescShadow_ff <= word[`PCR_PRESCALER_BIT];
    end
  end

  logic dblShadow_ff;
  logic halfShadow_ff;
  logic [9:0] rcntShadow_ff;
  logic dbufEn_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      noiseMode <= 2'h0;
      testMuxSel <= 3'h0;
      cpCurrent <= 3'h0;
      dbufEn_ff <= 1'b0;
      dblShadow_ff <= 1'b0;
      halfShadow_ff <= 1'b0;
      rcntShadow_ff <= `PCR_RST_RCNT;
    end else if (wrRefLoop) begin
      noiseMode <= word[`PCR_NOISE_LSB +: 2];
      testMuxSel <= word[`PCR_MUX_LSB +: 3];
      cpCurrent <= word[`PCR_CP_LSB +: 3];
      dbufEn_ff <= word[`PCR_DBUF_BIT];
      dblShadow_ff <= word[`PCR_DOUBLER_BIT];
      halfShadow_ff <= word[`PCR_HALVER_BIT];
      rcntShadow_ff <= word[`PCR_RCNT_LSB +: 10];
    end
  end

  logic lockCountSel_ff;
  logic lockWindowSel_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lockCountSel_ff <= 1'b0;
      lockWindowSel_ff <= 1'b0;
    end else if (wrRefLoop) begin
      lockCountSel_ff <= word[`PCR_LCOUNT_BIT];
      lockWindowSel_ff <= word[`PCR_LWIN_BIT];
    end
  end

  assign ditherEn = noiseMode == `PCR_NOISE_LOW_SPUR;

  // active copies of buffered fields move only on the integer/fraction write
  logic doubler_ff;
  logic halver_ff;
  logic [9:0] rcnt_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fraction_modulus <= `PCR_RST_MODULUS;
      phaseValue <= `PCR_RST_PHASE;
      prescaler_select <= 1'b0;
      doubler_ff <= 1'b0;
      halver_ff <= 1'b0;
      rcnt_ff <= `PCR_RST_RCNT;
    end else if (wrIntFraction) begin
      fraction_modulus <= modulusShadow_ff;
      phaseValue <= phaseShadow_ff;
      prescaler_select <= prescShadow_ff;
      doubler_ff <= dblShadow_ff;
      halver_ff <= halfShadow_ff;
      rcnt_ff <= rcntShadow_ff;
    end
  end

  logic [2:0] outDivShadow_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) outDivShadow_ff <= 3'h0;
    else if (wrOutCtrl) outDivShadow_ff <= word[`PCR_OUTDIV_LSB +: 3];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) outDivSel <= 3'h0;
    else if (wrOutCtrl && !dbufEn_ff) outDivSel <= word[`PCR_OUTDIV_LSB +: 3];
    else if (wrIntFraction && dbufEn_ff) outDivSel <= outDivShadow_ff;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      antibacklash_width <= 2'h0;
      charge_cancel_enable <= 1'b0;
      lockPinMode <= 2'h0;
    end else if (latchRise && sel == `PCR_SEL_LOCK_PIN) begin
      antibacklash_width <= word[`PCR_BACKLASH_LSB +: 2];
      charge_cancel_enable <= word[`PCR_CCE_BIT];
      lockPinMode <= word[`PCR_LDPIN_LSB +: 2];
    end
  end

  // reference path: edge select, R counter, optional halver
  logic refActive;
  logic [9:0] rCount_ff;
  logic rTerm;
  logic halfTog_ff;
  assign refActive = doubler_ff ? (refIn != refIn_ff) : (!refIn && refIn_ff);
  // a zero ratio is illegal; it is served as a ratio of one
  assign rTerm = refActive && (rCount_ff + 10'h001 >= rcnt_ff);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rCount_ff <= 10'h000;
    else if (rTerm) rCount_ff <= 10'h000;
    else if (refActive) rCount_ff <= rCount_ff + 10'h001;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) halfTog_ff <= 1'b0;
    else if (rTerm) halfTog_ff <= !halfTog_ff;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) detRefTick <= 1'b0;
    else detRefTick <= halver_ff ? (rTerm && !halfTog_ff) : rTerm;
  end

  pcr_lock_if lkIf ();
  assign lkIf.refTick = detRefTick;
  assign lkIf.fbEdge = fbEdge;
  assign lkIf.lockCountSelect = lockCountSel_ff;
  assign lkIf.lockWindowSelect = lockWindowSel_ff;
  assign lockDetect = lkIf.lockDet;

  pcr_lock_detect uLock (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .lk(lkIf.det)
  );

  // mux code map: 0 low, 1 high, 2 reference tick, 3 feedback, 4 lock, 5..7 low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) test_mux_output <= 1'b0;
    else begin
      case (testMuxSel)
        3'h1: test_mux_output <= 1'b1;
        3'h2: test_mux_output <= detRefTick;
        3'h3: test_mux_output <= fbEdge;
        3'h4: test_mux_output <= lockDetect;
        default: test_mux_output <= 1'b0;
      endcase
    end
  end

  sequence s_load_r1;
    wrModulusPhase ##1 !wrIntFraction;
  endsequence
  a_int_load: assert property (@(posedge ref_clk) disable iff (!rstn)
    wrIntFraction |=> integerValue == $past(shift_ff[30:15])
      && fraction_numerator == $past(shift_ff[14:3]))
    else $error("integer/fraction word not loaded");
  a_modulus_shadowed: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_load_r1 |-> $stable(fraction_modulus)
      && modulusShadow_ff == $past(shift_ff[14:3]))
    else $error("modulus changed before integer write");
  a_apply_on_int: assert property (@(posedge ref_clk) disable iff (!rstn)
    wrIntFraction |=> fraction_modulus == $past(modulusShadow_ff)
      && prescaler_select == $past(prescShadow_ff) && rcnt_ff == $past(rcntShadow_ff))
    else $error("buffered fields not applied");
  a_ref_loop_load: assert property (@(posedge ref_clk) disable iff (!rstn)
    wrRefLoop |=> cpCurrent == $past(shift_ff[11:9]) && testMuxSel == $past(shift_ff[28:26]))
    else $error("reference/loop word not loaded");
  a_outdiv_buffered: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wrOutCtrl && dbufEn_ff) ##1 !wrIntFraction |-> $stable(outDivSel))
    else $error("output divider changed without integer write");
  a_doubler_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
    !doubler_ff && refIn && !refIn_ff |-> !refActive)
    else $error("rising reference edge counted with doubler off");
endmodule // pcr_top
`default_nettype wire

// ### tb/pcr_host_model.sv
/*
  Host controller model: writes 32-bit words over the three serial pins.
  Assumes it is called at a rising edge of ref_clk and that ref_clk is the
  sampling clock of the decoder.
*/
`timescale 1ns/100ps
`default_nettype none
module pcr_host_model (
  input wire logic ref_clk,
  output logic serClk,
  output logic serData,
  output logic latchEn
);
  initial begin
    serClk = 1'b0;
    serData = 1'b0;
    latchEn = 1'b0;
  end

  // each serial phase lasts two cycles, twice the one-cycle phase the decoder can sample
  task automatic write_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serData <= w[i];
      serClk <= 1'b0;
      repeat (2) @(posedge ref_clk);
      serClk <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
    serClk <= 1'b0;
    // data is no longer qualified: show the inverse so a stale sample shows up
    serData <= ~w[0];
    repeat (2) @(posedge ref_clk);
    latchEn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    latchEn <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule // pcr_host_model
`default_nettype wire

// ### tb/tb_pll_config_register_decode.sv
/*
  Self-checking bench of the PLL configuration decoder.
  Assumes the host model drives the serial pins and ref_clk runs at 200 MHz.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcr_regs.svh"
module tb_pll_config_register_decode;
  import pcr_pkg::*;
  logic ref_clk, rstn, refIn, fbEdge, serClk, serData, latchEn;
  logic [15:0] integerValue;
  logic [11:0] fraction_numerator, fraction_modulus, phaseValue;
  logic [1:0] noiseMode, antibacklash_width, lockPinMode;
  logic [2:0] testMuxSel, cpCurrent, outDivSel;
  logic prescaler_select, ditherEn, test_mux_output, charge_cancel_enable;
  logic detRefTick, lockDetect;
  pcr_sel_t lastSel;
  logic [3:0] tickDly;
  logic [2:0] refCnt;
  int fbDelay, cyc, error_cnt, n_tests;

  pcr_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .serClk(serClk), .serData(serData),
    .latchEn(latchEn), .refIn(refIn), .fbEdge(fbEdge), .integerValue(integerValue),
    .fraction_numerator(fraction_numerator), .fraction_modulus(fraction_modulus),
    .phaseValue(phaseValue), .prescaler_select(prescaler_select), .noiseMode(noiseMode),
    .ditherEn(ditherEn), .testMuxSel(testMuxSel), .test_mux_output(test_mux_output),
    .cpCurrent(cpCurrent), .outDivSel(outDivSel), .antibacklash_width(antibacklash_width),
    .charge_cancel_enable(charge_cancel_enable), .lockPinMode(lockPinMode),
    .detRefTick(detRefTick), .lockDetect(lockDetect), .lastSel(lastSel));
  pcr_host_model u_host (.ref_clk(ref_clk), .serClk(serClk), .serData(serData),
    .latchEn(latchEn));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // reference of period eight cycles; feedback echoes the tick after fbDelay cycles
  always @(posedge ref_clk) begin
    refCnt <= refCnt + 3'h1;
    refIn <= refCnt[2];
    tickDly <= {tickDly[2:0], detRefTick};
    fbEdge <= (fbDelay == 1) ? detRefTick : tickDly[fbDelay-2];
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [31:0] mk2(logic [1:0] nm, logic [2:0] mx, logic dbl, logic hlv,
      logic [9:0] r, logic dbuf, logic [2:0] cp, logic lc, logic lw);
    // reserved bit 6 is written as one
    return {1'b0, nm, mx, dbl, hlv, r, dbuf, 1'b0, cp, lc, lw, 1'b1, 3'h0, 3'h2};
  endfunction

  task automatic wait_tick();
    do @(posedge ref_clk); while (detRefTick !== 1'b1);
  endtask

  task automatic t_reset();
    chk(32'(fraction_modulus), 32'h1);
    chk(32'(phaseValue), 32'h1);
    chk(32'(integerValue), 32'h0);
    chk(32'(lockDetect), 32'h0);
  endtask

  task automatic t_buffer();
    u_host.write_word(mk2(2'h3, 3'h1, 1'b0, 1'b0, 10'h1, 1'b0, 3'h5, 1'b1, 1'b0));
    chk(32'(noiseMode), 32'h3);
    chk(32'(ditherEn), 32'h1);
    chk(32'(testMuxSel), 32'h1);
    chk(32'(test_mux_output), 32'h1);
    chk(32'(cpCurrent), 32'h5);
    chk(32'(lastSel), 32'h2);
    // phase word one and 8/9 prescaler with integer 120
    u_host.write_word({4'h0, 1'b1, 12'h001, 12'h019, 3'h1});
    chk(32'(fraction_modulus), 32'h1);
    chk(32'(prescaler_select), 32'h0);
    u_host.write_word({1'b0, 16'h0078, 12'h001, 3'h0});
    chk(32'(integerValue), 32'h78);
    chk(32'(fraction_numerator), 32'h1);
    chk(32'(fraction_modulus), 32'h19);
    chk(32'(phaseValue), 32'h1);
    chk(32'(prescaler_select), 32'h1);
    chk(32'(lastSel), 32'h0);
  endtask

  task automatic t_refuse();
    logic [2:0] s[3] = '{3'h3, 3'h6, 3'h7};
    foreach (s[i]) begin
      u_host.write_word({1'b0, 16'hFFFF, 12'hFFF, s[i]});
      chk(32'(integerValue), 32'h78);
      chk(32'(fraction_modulus), 32'h19);
    end
  endtask

  task automatic t_divsel();
    u_host.write_word({9'h0, 3'h3, 17'h0, 3'h4});
    chk(32'(outDivSel), 32'h3);
    u_host.write_word(mk2(2'h0, 3'h0, 1'b0, 1'b0, 10'h1, 1'b1, 3'h0, 1'b1, 1'b0));
    chk(32'(ditherEn), 32'h0);
    chk(32'(test_mux_output), 32'h0);
    u_host.write_word({9'h0, 3'h5, 17'h0, 3'h4});
    chk(32'(outDivSel), 32'h3);
    u_host.write_word({1'b0, 16'h0078, 12'h001, 3'h0});
    chk(32'(outDivSel), 32'h5);
  endtask

  task automatic t_lockpin();
    u_host.write_word({2'h2, 1'b1, 1'b1, 4'h0, 2'h1, 19'h0, 3'h5});
    chk(32'(antibacklash_width), 32'h2);
    chk(32'(charge_cancel_enable), 32'h1);
    chk(32'(lockPinMode), 32'h1);
  endtask

  // the tick period shows doubler, halver and divider together after the apply write
  task automatic t_refdiv(input logic dbl, input logic hlv, input logic [9:0] r,
      input int exp);
    int n;
    u_host.write_word(mk2(2'h0, 3'h2, dbl, hlv, r, 1'b0, 3'h0, 1'b1, 1'b0));
    u_host.write_word({1'b0, 16'h0078, 12'h001, 3'h0});
    wait_tick();
    wait_tick();
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (detRefTick !== 1'b1 && n < 200);
    chk(32'(n), 32'(exp));
    // mux code 2 echoes the tick one cycle later
    @(posedge ref_clk);
    chk(32'(test_mux_output), 32'h1);
  endtask

  task automatic t_lock(input logic lc, input logic lw, input int dly, input logic exp);
    int thr;
    thr = lc ? `PCR_LOCK_CNT_SHORT : `PCR_LOCK_CNT_LONG;
    fbDelay = 3;
    u_host.write_word(mk2(2'h0, 3'h4, 1'b0, 1'b0, 10'h1, 1'b0, 3'h0, lc, lw));
    chk(32'(lockDetect), 32'h0);
    fbDelay = dly;
    repeat (thr - 2) wait_tick();
    chk(32'(lockDetect), 32'h0);
    repeat (6) wait_tick();
    chk(32'(lockDetect), 32'(exp));
    chk(32'(test_mux_output), 32'(exp));
    fbDelay = 3;
    repeat (2) wait_tick();
    chk(32'(lockDetect), 32'h0);
  endtask

  initial begin
    rstn = 1'b0;
    refIn = 1'b0;
    fbEdge = 1'b0;
    tickDly = 4'h0;
    refCnt = 3'h0;
    fbDelay = 3;
    cyc = 0;
    error_cnt = 0;
    n_tests = 0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_lockpin();
    t_buffer();
    t_refuse();
    t_divsel();
    t_refdiv(1'b0, 1'b0, 10'h1, 8);
    t_refdiv(1'b1, 1'b0, 10'h1, 4);
    t_refdiv(1'b0, 1'b1, 10'h1, 16);
    t_refdiv(1'b0, 1'b0, 10'h3, 24);
    t_lock(1'b1, 1'b1, 1, 1'b1);
    t_lock(1'b0, 1'b0, 2, 1'b1);
    t_lock(1'b1, 1'b1, 2, 1'b0);
    tally_and_finish();
  end
endmodule // tb_pll_config_register_decode
`default_nettype wire
